// ---- hw/srx_pkg.sv ----
// receive status/control register bank: shared constants
// assumes 7-bit link register index and 16-bit register data
//
// Notes on behaviour
// [RULE1] status bit 15 flags any invalid subframe
// [RULE2] status bit 14 shows receiver lock
// [RULE3] status bits 11:8 carry received sample rate
// [RULE4] control bit 15 enables receiver, claims pin
// [RULE5] monitoring bits 14/11 mix samples into DAC
// [RULE6] control bit 13 loops transmitter into receiver
// [RULE7] control bit 12 picks capture stream source
// [RULE8] control bits 9:8 read rate-decode result
// [RULE9] control bit 1 shows receive line on GPIO
// [RULE10] control bit 0 zeroes invalid transmit data
// [RULE11] vendor id: writable, ffff unloaded, else zero
// [RULE12] subsystem id valid at ready, same rules
// [RULE13] DAC map bits 15:12 writable, reset 376a
// [RULE14] ADC map bit 0 says DAC map valid
// [RULE15] ids and maps only on page 01
// [RULE16] channel status registers only on page 00
// [RULE17] status refreshed continuously, no write needed
package srx_pkg;
  // ==========================================================
  // register index map
  localparam int         ADDR_W    = 7;
  localparam int         DATA_W    = 16;
  localparam logic [6:0] OFS_PAGE  = 7'h24;
  localparam logic [6:0] OFS_SVID  = 7'h62;
  localparam logic [6:0] OFS_SID   = 7'h64;
  localparam logic [6:0] OFS_CSLO  = 7'h66;
  localparam logic [6:0] OFS_CSHI  = 7'h68;
  localparam logic [6:0] OFS_CTRL  = 7'h6a;
  localparam logic [6:0] OFS_DMAP  = 7'h6c;
  localparam logic [6:0] OFS_AMAP  = 7'h6e;
  // ==========================================================
  // pages
  localparam logic [3:0] PAGE_STD  = 4'h0;
  localparam logic [3:0] PAGE_EXT  = 4'h1;
  // ==========================================================
  // reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] SUBSYS_RST = 16'hffff;
  localparam logic [15:0] DMAP_RST   = 16'h376a;
  localparam logic [15:0] AMAP_RST   = 16'h0000;
  // ==========================================================
  // control field positions
  localparam int CTL_RX_EN   = 15;
  localparam int CTL_MON_A   = 14;
  localparam int CTL_LOOP    = 13;
  localparam int CTL_CAP_SEL = 12;
  localparam int CTL_MON_B   = 11;
  localparam int CTL_RATE_LO = 8;
  localparam int CTL_OBS     = 1;
  localparam int CTL_TXCLR   = 0;
  localparam logic [15:0] CTL_WR_MASK = 16'hfcff;
  // ==========================================================
  // status and map field positions
  localparam int ST_INVALID  = 15;
  localparam int ST_LOCK     = 14;
  localparam int MAP_LSB     = 12;
  localparam logic [3:0] MAP_CODE_MAX = 4'hb;
endpackage : srx_pkg

// ---- hw/srx_sync.sv ----
// two-stage level synchroniser, any width
// assumes each bit is an independent, slowly changing level
`timescale 1ns/1ps
module srx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // a zero-width chain has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("srx_sync: width must be at least 1");
  end

  // ==========================================================
  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta_reg <= din;
    dout     <= meta_reg;
  end
endmodule : srx_sync

// ---- hw/srx_word_cdc.sv ----
// toggle-handshake word crossing between two clocks
// assumes source word may change every cycle; latest is sent
`timescale 1ns/1ps
module srx_word_cdc #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic [W-1:0] src_word,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_word
);
  logic [W-1:0] hold_reg;
  logic         req_reg;
  logic         ack_s;
  logic         req_s;
  logic         seen_reg;

  // a zero-width word has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("srx_word_cdc: width must be at least 1");
  end

  // ==========================================================
  // source side: relaunch once the last word was taken
  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      hold_reg <= '0;
      req_reg  <= 1'b0;
    end else if (ack_s == req_reg) begin
      hold_reg <= src_word;
      req_reg  <= ~req_reg;
    end
  end

  srx_sync #(.W(1)) u_req (
    .clk  (dst_clk),
    .din  (req_reg),
    .dout (req_s)
  );

  // ==========================================================
  // dest side: hold_reg is stable while request is open
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      dst_word <= '0;
      seen_reg <= 1'b0;
    end else if (req_s != seen_reg) begin
      dst_word <= hold_reg;
      seen_reg <= req_s;
    end
  end

  srx_sync #(.W(1)) u_ack (
    .clk  (src_clk),
    .din  (seen_reg),
    .dout (ack_s)
  );
endmodule : srx_word_cdc

// ---- hw/srx_regs.sv ----
// receive status/control register bank and its datapath hooks
// assumes decoded link commands on bit_clk, receiver on clk_sys
`timescale 1ns/1ps
module srx_regs
  import srx_pkg::*;
#(
  parameter int SW          = 20,
  parameter bit SUBSYS_IMPL = 1'b1
) (
  // link side, bit_clk domain
  input  wire logic          bit_clk,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_write,
  input  wire logic [6:0]    cmd_addr,
  input  wire logic [15:0]   cmd_wdata,
  output logic               rsp_valid,
  output logic               rsp_hit,
  output logic [15:0]        rsp_data,
  output logic [3:0]         front_slot_map,
  // system side, clk_sys domain
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          rx_locked,
  input  wire logic          rx_invalid_x,
  input  wire logic          rx_invalid_y,
  input  wire logic [3:0]    rx_cs_fs,
  input  wire logic [1:0]    rx_cs_acc,
  input  wire logic [3:0]    rx_cs_chan,
  input  wire logic [3:0]    rx_cs_src,
  input  wire logic [15:0]   rx_cs_lo,
  input  wire logic [1:0]    rx_rate,
  input  wire logic [SW-1:0] rx_sample,
  input  wire logic [SW-1:0] pcm_sample,
  input  wire logic [SW-1:0] adc_sample,
  input  wire logic [SW-1:0] tx_sample,
  input  wire logic          tx_invalid,
  input  wire logic          tx_serial,
  input  wire logic          external_amp_powerdown,
  input  wire logic          share_pin_in,
  output logic               share_pin_out,
  output logic               share_pin_oe,
  output logic               rx_enable,
  output logic               rx_line,
  output logic               gpio_obs_out,
  output logic               gpio_obs_oe,
  output logic [SW-1:0]      dac_sample,
  output logic [SW-1:0]      capture_sample,
  output logic [SW-1:0]      tx_out_sample
);
  // ==========================================================
  // elaboration checks
  if (SW < 2 || SW > 32) begin : g_bad_sw
    $error("srx_regs: sample width must be 2..32");
  end

  // ==========================================================
  // saturating signed add: the mixed stream may clip
  function automatic logic [SW-1:0] sat_add(
    input logic [SW-1:0] a,
    input logic [SW-1:0] b
  );
    logic [SW:0] s;
    s = {a[SW-1], a} + {b[SW-1], b};
    if (s[SW] != s[SW-1]) begin
      return s[SW] ? {1'b1, {(SW-1){1'b0}}}
                   : {1'b0, {(SW-1){1'b1}}};
    end
    return s[SW-1:0];
  endfunction : sat_add

  // true when the given page is the selected one
  function automatic logic on_page(
    input logic [3:0] cur,
    input logic [3:0] want
  );
    return cur == want;
  endfunction : on_page

  // ==========================================================
  // declarations
  localparam int STW = 34;

  logic            link_rst_n;
  logic [3:0]      page_reg;
  logic [15:0]     ctrl_reg;
  logic [15:0]     svid_reg;
  logic [15:0]     sid_reg;
  logic [3:0]      dmap_reg;
  logic [STW-1:0]  stat_sys_reg;
  logic [STW-1:0]  stat_link;
  logic [15:0]     cshi_link;
  logic [15:0]     cslo_link;
  logic [1:0]      rate_link;
  logic [15:0]     rd_data;
  logic            rd_hit;
  logic            map_ok;
  logic            pg_std;
  logic            pg_ext;
  logic            wr;
  logic [15:0]     ctrl_sys;
  logic            pin_s;
  logic            rx_line_next;

  // ==========================================================
  // link reset: nrst is foreign to bit_clk, so resynchronise
  srx_sync #(.W(1)) u_lrst (
    .clk  (bit_clk),
    .din  (nrst),
    .dout (link_rst_n)
  );

  // ==========================================================
  // receiver status snapshot, refreshed every system cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stat_sys_reg <= '0;
    end else begin
      stat_sys_reg <= {rx_rate,                       // RULE8
                       rx_invalid_x | rx_invalid_y,   // RULE1
                       rx_locked,                     // RULE2
                       rx_cs_acc,
                       rx_cs_fs,                      // RULE3
                       rx_cs_chan,
                       rx_cs_src,
                       rx_cs_lo};
    end
  end

  // status words reach the link without any write
  srx_word_cdc #(.W(STW)) u_stat (
    .src_clk   (clk_sys),
    .src_rst_n (nrst),
    .src_word  (stat_sys_reg),                        // RULE17
    .dst_clk   (bit_clk),
    .dst_rst_n (link_rst_n),
    .dst_word  (stat_link)
  );

  assign rate_link = stat_link[33:32];
  assign cshi_link = stat_link[31:16];
  assign cslo_link = stat_link[15:0];

  // ==========================================================
  // page and write qualifiers
  assign pg_std = on_page(page_reg, PAGE_STD);        // RULE16
  assign pg_ext = on_page(page_reg, PAGE_EXT);        // RULE15
  assign wr     = cmd_valid & cmd_write;

  // page select register
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      page_reg <= PAGE_STD;
    end else if (wr && cmd_addr == OFS_PAGE) begin
      page_reg <= cmd_wdata[3:0];
    end
  end

  // ==========================================================
  // receive control: rate field is never stored
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && pg_std && cmd_addr == OFS_CTRL) begin
      ctrl_reg <= cmd_wdata & CTL_WR_MASK;
    end
  end

  // ==========================================================
  // subsystem ids: unimplemented build reads zero, ignores writes
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      svid_reg <= SUBSYS_IMPL ? SUBSYS_RST : 16'h0000; // RULE11
      sid_reg  <= SUBSYS_IMPL ? SUBSYS_RST : 16'h0000; // RULE12
    end else if (wr && pg_ext && SUBSYS_IMPL) begin    // RULE15
      if (cmd_addr == OFS_SVID) begin
        svid_reg <= cmd_wdata;                         // RULE11
      end
      if (cmd_addr == OFS_SID) begin
        sid_reg <= cmd_wdata;                          // RULE12
      end
    end
  end

  // ==========================================================
  // front DAC slot map; only the top nibble is writable
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      dmap_reg <= DMAP_RST[15:12];                    // RULE13
    end else if (wr && pg_ext && cmd_addr == OFS_DMAP) begin
      dmap_reg <= cmd_wdata[15:12];                   // RULE13
    end
  end

  assign map_ok = dmap_reg <= MAP_CODE_MAX;           // RULE14

  // ==========================================================
  // read decode; out-of-page or unknown index misses
  always_comb begin
    rd_data = 16'h0000;
    rd_hit  = 1'b0;
    case (cmd_addr)
      OFS_PAGE: begin
        rd_data = {12'h000, page_reg};
        rd_hit  = 1'b1;
      end
      OFS_CSLO: begin
        rd_data = pg_std ? cslo_link : 16'h0000;      // RULE16
        rd_hit  = pg_std;
      end
      OFS_CSHI: begin
        rd_data = pg_std ? cshi_link : 16'h0000;      // RULE16
        rd_hit  = pg_std;
      end
      OFS_CTRL: begin
        rd_data = ctrl_reg;
        rd_data[CTL_RATE_LO +: 2] = rate_link;        // RULE8
        rd_hit  = pg_std;
        if (!pg_std) begin
          rd_data = 16'h0000;
        end
      end
      OFS_SVID: begin
        rd_data = pg_ext ? svid_reg : 16'h0000;       // RULE15
        rd_hit  = pg_ext;
      end
      OFS_SID: begin
        rd_data = pg_ext ? sid_reg : 16'h0000;        // RULE15
        rd_hit  = pg_ext;
      end
      OFS_DMAP: begin
        rd_data = pg_ext ? {dmap_reg, DMAP_RST[11:0]} // RULE13
                         : 16'h0000;
        rd_hit  = pg_ext;
      end
      OFS_AMAP: begin
        rd_data = pg_ext ? (AMAP_RST | {15'h0000, map_ok})
                         : 16'h0000;                  // RULE14
        rd_hit  = pg_ext;
      end
      default: begin
        rd_data = 16'h0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // read answer, one bit_clk after the command
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      rsp_valid <= 1'b0;
      rsp_hit   <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid & ~cmd_write;
      if (cmd_valid && !cmd_write) begin
        rsp_hit  <= rd_hit;
        rsp_data <= rd_data;                          // RULE17
      end
    end
  end

  // slot map output held from its own register
  always_ff @(posedge bit_clk) begin
    if (!link_rst_n) begin
      front_slot_map <= DMAP_RST[15:12];
    end else begin
      front_slot_map <= dmap_reg;                     // RULE13
    end
  end

  // ==========================================================
  // control into system domain; bits are independent levels,
  // so a two-flop chain per bit is enough
  srx_sync #(.W(16)) u_ctrl (
    .clk  (clk_sys),
    .din  (ctrl_reg),
    .dout (ctrl_sys)
  );

  // shared pin input is asynchronous
  srx_sync #(.W(1)) u_pin (
    .clk  (clk_sys),
    .din  (share_pin_in),
    .dout (pin_s)
  );

  // ==========================================================
  // shared pin: receiver input or amplifier power-down output
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_enable     <= 1'b0;
      share_pin_oe  <= 1'b1;
      share_pin_out <= 1'b0;
    end else begin
      rx_enable     <= ctrl_sys[CTL_RX_EN];           // RULE4
      share_pin_oe  <= ~ctrl_sys[CTL_RX_EN];          // RULE4
      share_pin_out <= external_amp_powerdown
                       & ~ctrl_sys[CTL_RX_EN];        // RULE4
    end
  end

  // ==========================================================
  // receiver line: test loopback replaces the pin
  assign rx_line_next = ctrl_sys[CTL_LOOP] ? tx_serial // RULE6
                                           : pin_s;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_line <= 1'b0;
    end else begin
      rx_line <= rx_line_next & ctrl_sys[CTL_RX_EN];  // RULE4
    end
  end

  // ==========================================================
  // GPIO observation of the line the receiver sees
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gpio_obs_oe  <= 1'b0;
      gpio_obs_out <= 1'b0;
    end else begin
      gpio_obs_oe  <= ctrl_sys[CTL_OBS];              // RULE9
      gpio_obs_out <= ctrl_sys[CTL_OBS]
                      & rx_line_next
                      & ctrl_sys[CTL_RX_EN];          // RULE9
    end
  end

  // ==========================================================
  // DAC feed: received samples added when monitoring;
  // rates are not locked, so the mix may sound rough
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dac_sample <= '0;
    end else if (ctrl_sys[CTL_MON_A] || ctrl_sys[CTL_MON_B]) begin
      dac_sample <= sat_add(pcm_sample, rx_sample);   // RULE5
    end else begin
      dac_sample <= pcm_sample;
    end
  end

  // ==========================================================
  // capture stream source towards the controller
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      capture_sample <= '0;
    end else begin
      capture_sample <= ctrl_sys[CTL_CAP_SEL]         // RULE7
                        ? rx_sample : adc_sample;
    end
  end

  // ==========================================================
  // transmit data clearing for copy management
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_out_sample <= '0;
    end else if (ctrl_sys[CTL_TXCLR] && tx_invalid) begin
      tx_out_sample <= '0;                            // RULE10
    end else begin
      tx_out_sample <= tx_sample;                     // RULE10
    end
  end
endmodule : srx_regs

// ---- testbench/srx_regs_asserts.sv ----
// checker for the receive register bank: link answers, pin and datapath
// assumes only the top ports of srx_regs are visible; bound below
`timescale 1ns/1ps
module srx_regs_asserts
  import srx_pkg::*;
#(
  parameter int SW = 20
) (
  input wire logic          bit_clk,
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire logic          cmd_valid,
  input wire logic          cmd_write,
  input wire logic [6:0]    cmd_addr,
  input wire logic          rsp_valid,
  input wire logic          rsp_hit,
  input wire logic [15:0]   rsp_data,
  input wire logic [3:0]    front_slot_map,
  input wire logic          external_amp_powerdown,
  input wire logic          tx_invalid,
  input wire logic [SW-1:0] adc_sample,
  input wire logic [SW-1:0] rx_sample,
  input wire logic [SW-1:0] tx_sample,
  input wire logic          share_pin_out,
  input wire logic          share_pin_oe,
  input wire logic          rx_enable,
  input wire logic          rx_line,
  input wire logic [SW-1:0] capture_sample,
  input wire logic [SW-1:0] tx_out_sample
);
  // ==========================================================
  // link side: answers one edge after each read
  AST_RSP_PULSE: assert property (@(posedge bit_clk) disable iff (!nrst)
    rsp_valid == $past(cmd_valid && !cmd_write)) else $error("answer timing");
  AST_MISS_ZERO: assert property (@(posedge bit_clk) disable iff (!nrst)
    rsp_valid && !rsp_hit |-> rsp_data == 16'h0000) else $error("miss data");
  AST_UNMAPPED: assert property (@(posedge bit_clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_addr == 7'h70 |=> rsp_valid && !rsp_hit)
    else $error("unmapped hit");
  AST_AMAP: assert property (@(posedge bit_clk) disable iff (!nrst)
    rsp_valid && rsp_hit && $past(cmd_addr) == OFS_AMAP |->
    rsp_data == {15'h0000, front_slot_map <= MAP_CODE_MAX})
    else $error("map valid flag");
  AST_DMAP: assert property (@(posedge bit_clk) disable iff (!nrst)
    rsp_valid && rsp_hit && $past(cmd_addr) == OFS_DMAP |->
    rsp_data == {front_slot_map, DMAP_RST[11:0]}) else $error("dac map read");
  // ==========================================================
  // system side: pin ownership and sample muxes
  AST_PIN_OE: assert property (@(posedge clk_sys) disable iff (!nrst)
    share_pin_oe != rx_enable) else $error("pin enable");
  AST_PIN_OUT: assert property (@(posedge clk_sys) disable iff (!nrst)
    share_pin_out |-> !rx_enable && $past(external_amp_powerdown))
    else $error("pin level");
  AST_LINE_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rx_enable [*4] |-> !rx_line) else $error("line while off");
  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> capture_sample == $past(adc_sample) ||
    capture_sample == $past(rx_sample)) else $error("capture source");
  AST_TX_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) && !$past(tx_invalid) |-> tx_out_sample == $past(tx_sample))
    else $error("valid tx altered");
  // main scenarios reached
  cover property (@(posedge bit_clk) rsp_valid && !rsp_hit);
  cover property (@(posedge clk_sys) rx_enable && rx_line);
  cover property (@(posedge clk_sys) $past(tx_invalid) && tx_out_sample == '0);
endmodule : srx_regs_asserts

bind srx_regs srx_regs_asserts #(.SW(SW)) i_chk (.*);

// ---- testbench/srx_ctl_model.sv ----
// link controller model: issues register commands on bit_clk
// assumes callers enter each task just after a bit_clk rise
`timescale 1ns/1ps
module srx_ctl_model
  import srx_pkg::*;
(
  input  wire logic  bit_clk,
  output logic       cmd_valid,
  output logic       cmd_write,
  output logic [6:0] cmd_addr,
  output logic [15:0] cmd_wdata
);
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr  = 7'h00;
    cmd_wdata = 16'h0000;
  end
  // one command, held until the edge that takes it
  task automatic send(input logic w, input logic [6:0] a,
                      input logic [15:0] d);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    @(posedge bit_clk);
  endtask : send
  // released lines wander so a stale value is never trusted
  task automatic idle(input int n);
    repeat (n) begin
      #1;
      cmd_valid = 1'b0;
      cmd_write = ~cmd_write;
      cmd_addr  = ~cmd_addr;
      cmd_wdata = ~cmd_wdata;
      @(posedge bit_clk);
    end
  endtask : idle
  // page select always precedes page-bound accesses
  task automatic page(input logic [3:0] p);
    send(1'b1, OFS_PAGE, {12'h000, p});
  endtask : page
endmodule : srx_ctl_model

// ---- testbench/srx_regs_test.sv ----
// self-checking bench for the receive register bank
// assumes srx_ctl_model drives the link; reads checked from a queue
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module srx_regs_test
  import srx_pkg::*;
;
  localparam int SW = 20;
  logic clk_sys, bit_clk, nrst, cmd_valid, cmd_write, rsp_valid, rsp_hit;
  logic [6:0]    cmd_addr;
  logic [15:0]   cmd_wdata, rsp_data, rx_cs_lo, c, d;
  logic [3:0]    front_slot_map, rx_cs_fs, rx_cs_chan, rx_cs_src;
  logic [1:0]    rx_cs_acc, rx_rate;
  logic          rx_locked, rx_invalid_x, rx_invalid_y, tx_invalid;
  logic          tx_serial, external_amp_powerdown, ext_lvl, ln;
  logic          share_pin_out, share_pin_oe, rx_enable, rx_line;
  logic          gpio_obs_out, gpio_obs_oe;
  logic [SW-1:0] rx_sample, pcm_sample, adc_sample, tx_sample;
  logic [SW-1:0] dac_sample, capture_sample, tx_out_sample;
  logic [16:0]   expq[$];
  logic [16:0]   e;
  wire           share_pin_in;
  int            bad_count = 0;
  int            compares = 0;
  integer        seed = 32'hb164f258;
  logic [3:0]    fs_tab[3] = '{4'h0, 4'h2, 4'h3};
  logic [15:0]   ctl_tab[8] = '{16'h0000, 16'h8000, 16'hc003, 16'h8802,
                                16'ha402, 16'h9001, 16'h10fc, 16'h0301};

  srx_regs #(.SW(SW)) i_dut (.*);
  srx_ctl_model i_ctl (.*);
  // pin level: ours while the bank lets go of it
  assign share_pin_in = share_pin_oe ? share_pin_out : ext_lvl;

  // ==========================================================
  // clocks, unrelated in phase
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    bit_clk = 1'b0;
    #7;
    forever #40 bit_clk = ~bit_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [SW-1:0] sat(input logic [SW-1:0] a, b);
    logic signed [SW:0] s;
    s = $signed({a[SW-1], a}) + $signed({b[SW-1], b});
    if (s[SW] != s[SW-1]) return {s[SW], {(SW-1){~s[SW]}}};
    return s[SW-1:0];
  endfunction : sat
  // note the expected answer, then issue the read
  task automatic rd(input logic [6:0] a, input logic h, input logic [15:0] v);
    expq.push_back({h, v});
    i_ctl.send(1'b0, a, 16'h0000);
  endtask : rd
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // answers compared against the oldest note
  always @(posedge bit_clk) begin
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("ERROR %0t: answer with no read", $time);
      end else begin
        e = expq.pop_front();
        `CHK({rsp_hit, rsp_data}, e)
      end
    end
  end
  // watchdog well past the expected run length
  initial begin
    #200000;
    bad_count++;
    $display("ERROR %0t: timeout", $time);
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    {rx_locked, rx_invalid_x, rx_invalid_y, tx_invalid} = 4'h0;
    {rx_cs_fs, rx_cs_acc, rx_cs_chan, rx_cs_src} = 14'h0000;
    {rx_cs_lo, rx_rate} = 18'($random(seed));
    {tx_serial, external_amp_powerdown, ext_lvl} = 3'b000;
    {rx_sample, pcm_sample, adc_sample, tx_sample} = '0;
    // long enough for both domains to see reset
    repeat (25) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge bit_clk);
    // extended page: reset values, writes, map sweep
    i_ctl.page(PAGE_EXT);
    rd(OFS_PAGE, 1'b1, {12'h000, PAGE_EXT});
    rd(OFS_SVID, 1'b1, SUBSYS_RST);
    rd(OFS_SID, 1'b1, SUBSYS_RST);
    rd(OFS_DMAP, 1'b1, DMAP_RST);
    rd(OFS_AMAP, 1'b1, 16'h0001);
    rd(OFS_CTRL, 1'b0, 16'h0000);
    i_ctl.send(1'b1, OFS_CTRL, 16'hffff);
    d = 16'($random(seed));
    i_ctl.send(1'b1, OFS_SVID, d);
    i_ctl.send(1'b1, OFS_SID, ~d);
    rd(OFS_SVID, 1'b1, d);
    rd(OFS_SID, 1'b1, ~d);
    for (int m = 0; m < 16; m++) begin
      i_ctl.send(1'b1, OFS_DMAP, {m[3:0], 12'hfff});
      rd(OFS_DMAP, 1'b1, {m[3:0], DMAP_RST[11:0]});
      rd(OFS_AMAP, 1'b1, {15'h0000, m <= 11});
      `CHK(front_slot_map, m[3:0])
    end
    rd(7'h70, 1'b0, 16'h0000);
    // standard page: vendor id hidden, off-page write had no effect
    i_ctl.page(PAGE_STD);
    rd(OFS_SVID, 1'b0, 16'h0000);
    rd(OFS_CTRL, 1'b1, {6'h00, rx_rate, 8'h00});
    i_ctl.idle(1);
    // status follows the receiver with no write in between
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      {rx_invalid_x, rx_invalid_y, rx_locked} = i[2:0];
      rx_cs_fs = fs_tab[i % 3];
      {rx_cs_acc, rx_cs_chan, rx_cs_src, rx_cs_lo, rx_rate} = 28'($random(seed));
      @(posedge bit_clk);
      i_ctl.idle(8);
      rd(OFS_CSHI, 1'b1, {rx_invalid_x | rx_invalid_y, rx_locked, rx_cs_acc,
         rx_cs_fs, rx_cs_chan, rx_cs_src});
      rd(OFS_CSLO, 1'b1, rx_cs_lo);
      rd(OFS_CTRL, 1'b1, {6'h00, rx_rate, 8'h00});
      i_ctl.idle(1);
    end
    // control bits steer pin, loopback, mixes and clearing
    foreach (ctl_tab[k]) begin
      c = ctl_tab[k];
      @(posedge bit_clk);
      i_ctl.send(1'b1, OFS_CTRL, c);
      rd(OFS_CTRL, 1'b1, (c & CTL_WR_MASK) | {6'h00, rx_rate, 8'h00});
      i_ctl.idle(1);
      @(posedge clk_sys);
      #1;
      rx_sample = SW'($random(seed));
      pcm_sample = SW'($random(seed));
      adc_sample = SW'($random(seed));
      tx_sample = SW'($random(seed));
      {tx_invalid, tx_serial, external_amp_powerdown, ext_lvl} = 4'($random(seed));
      // pin input needs three cycles; ctrl crossing already settled
      repeat (12) @(posedge clk_sys);
      #1;
      ln = c[15] & (c[13] ? tx_serial : ext_lvl);
      `CHK(rx_enable, c[15])
      `CHK(share_pin_oe, ~c[15])
      `CHK(share_pin_out, external_amp_powerdown & ~c[15])
      `CHK(rx_line, ln)
      `CHK(gpio_obs_oe, c[1])
      `CHK(gpio_obs_out, c[1] & ln)
      `CHK(capture_sample, c[12] ? rx_sample : adc_sample)
      `CHK(tx_out_sample, (c[0] & tx_invalid) ? '0 : tx_sample)
      `CHK(dac_sample, (c[14] | c[11]) ? sat(pcm_sample, rx_sample) : pcm_sample)
    end
    @(posedge bit_clk);
    i_ctl.idle(3);
    `CHK(expq.size(), 0)
    conclude();
  end
endmodule : srx_regs_test
